// ### abm_matrix.sv
// AHB multilayer bus matrix: four masters, four slaves, per-slave arbiters
`timescale 1ns/1ps
module abm_matrix #(
	parameter int AW = abm_pkg::AW, // Address width
	parameter int DW = abm_pkg::DW  // Data width
) (
	input  wire logic               clk,          // System clock
	input  wire logic               rstn,         // Async reset, active low
	input  wire logic [3:0][AW-1:0] m_haddr,      // Master addresses
	input  wire logic [3:0][1:0]    m_htrans,     // Master transfer types
	input  wire logic [3:0]         m_hwrite,     // Master write flags
	input  wire logic [3:0][2:0]    m_hsize,      // Master sizes
	input  wire logic [3:0][DW-1:0] m_hwdata,     // Master write data
	output logic      [3:0][DW-1:0] m_hrdata,     // Read data to masters
	output logic      [3:0]         m_hready,     // Ready to masters
	output logic      [3:0][1:0]    m_hresp,      // Response to masters
	output logic      [3:0][AW-1:0] s_haddr,      // Slave addresses
	output logic      [3:0][1:0]    s_htrans,     // Slave transfer types
	output logic      [3:0]         s_hwrite,     // Slave write flags
	output logic      [3:0][2:0]    s_hsize,      // Slave sizes
	output logic      [3:0][DW-1:0] s_hwdata,     // Slave write data
	output logic      [3:0][3:0]    s_hmaster,    // Granted master, one-hot
	input  wire logic [3:0][DW-1:0] s_hrdata,     // Slave read data
	input  wire logic [3:0]         s_hready,     // Slave ready
	input  wire logic [3:0][1:0]    s_hresp,      // Slave response
	output logic                    lsp_clk_en,   // Low-speed bus enable
	output logic                    hsp_clk_en    // High-speed bus enable
);
	// Slave index decode of an address; 4 means unmapped
	function automatic logic [2:0] abm_decode(input logic [AW-1:0] a);
		logic [2:0]    s;
		logic [AW-1:0] win;
		s = 3'h4;
		// Peripheral space is compared by 1 KB window index only
		win = a >> abm_pkg::PERIPH_WIN_LSB;
		if ((a >= abm_pkg::FLASH_ALIAS_BASE && a <= abm_pkg::FLASH_ALIAS_END)
		    || (a >= abm_pkg::FLASH_MAIN_BASE && a <= abm_pkg::FLASH_MAIN_END)
		    || (a >= abm_pkg::FLASH_DATA_BASE && a <= abm_pkg::FLASH_DATA_END)
		    || (a >= abm_pkg::FLASH_SYS_BASE && a <= abm_pkg::FLASH_SYS_END)) begin
			s = 3'h0;
		end else if ((a >= abm_pkg::SRAM_CODE_BASE && a <= abm_pkg::SRAM_CODE_END)
		    || (a >= abm_pkg::SRAM_SYS_BASE && a <= abm_pkg::SRAM_SYS_END)) begin
			s = 3'h1;
		end else if (win >= (abm_pkg::GPIO_BASE >> abm_pkg::PERIPH_WIN_LSB)
		    && win <= (abm_pkg::GPIO_END >> abm_pkg::PERIPH_WIN_LSB)) begin
			s = 3'h3;
		end else if (win >= (abm_pkg::PERIPH_BASE >> abm_pkg::PERIPH_WIN_LSB)
		    && win <= (abm_pkg::PERIPH_END >> abm_pkg::PERIPH_WIN_LSB)) begin
			s = 3'h2;
		end
		return s;
	endfunction

	// Connectivity check for a master and slave pair
	function automatic logic abm_allowed(input logic [2:0] s, input int m);
		logic [3:0] c;
		case (s)
			3'h0:    c = abm_pkg::CONN_FLASH;
			3'h1:    c = abm_pkg::CONN_SRAM;
			3'h2:    c = abm_pkg::CONN_PERIPH;
			3'h3:    c = abm_pkg::CONN_GPIO;
			default: c = 4'h0;
		endcase
		return c[m];
	endfunction

	logic [3:0][2:0] req_slv;   // Decoded slave per master
	logic [3:0]      req_vld;   // Legal request per master
	logic [3:0]      req_bad;   // Request with no path
	logic [3:0][3:0] req_mat;   // Requests indexed by slave
	logic [3:0][3:0] gnt;       // Address phase grant per slave
	logic [3:0]      mst_wait;  // Master held in its own data phase
	logic [3:0][3:0] dph_ff;    // Data phase owner per slave
	logic [3:0][3:0] nxt_dph;
	logic [3:0][1:0] rr_ff;     // Round-robin pointer per slave
	logic [3:0][1:0] nxt_rr;
	logic [3:0]      err_ff;    // Error data phase per master
	logic [3:0]      nxt_err;
	logic [3:0]      err_end_ff; // Second error cycle pending
	logic [3:0]      nxt_err_end;
	logic            div_ff;    // Clock divider for the low-speed peripheral bus
	logic            nxt_div;

	// Request decode per master; a master held in a data phase offers nothing
	always_comb begin
		for (int m = 0; m < 4; m++) begin
			mst_wait[m] = err_ff[m];
			for (int s = 0; s < 4; s++) begin
				if (dph_ff[s][m] && !s_hready[s]) mst_wait[m] = 1'b1;
			end
			req_slv[m] = abm_decode(m_haddr[m]);
			req_vld[m] = m_htrans[m][1] && !mst_wait[m]
			    && abm_allowed(req_slv[m], m);
			req_bad[m] = m_htrans[m][1] && !abm_allowed(req_slv[m], m);
			for (int s = 0; s < 4; s++) begin
				req_mat[s][m] = req_vld[m] && (req_slv[m] == 3'(s));
			end
		end
	end

	// Per-slave round-robin arbitration; slaves arbitrate independently
	always_comb begin
		logic [1:0] idx;
		idx = 2'h0;
		gnt     = '0;
		nxt_dph = dph_ff;
		nxt_rr  = rr_ff;
		for (int s = 0; s < 4; s++) begin
			// A stalled slave keeps its data phase owner and takes no address
			if (s_hready[s]) begin
				for (int k = 4; k >= 1; k--) begin
					idx = 2'(rr_ff[s] + 2'(k));
					if (req_mat[s][idx]) begin
						gnt[s] = 4'h1 << idx;
					end
				end
				// The address taken now owns the next data phase
				nxt_dph[s] = gnt[s];
				for (int m = 0; m < 4; m++) begin
					if (gnt[s][m]) nxt_rr[s] = 2'(m);
				end
			end
		end
	end

	// Error response is two cycles: hready low then high
	always_comb begin
		for (int m = 0; m < 4; m++) begin
			nxt_err[m]     = req_bad[m] && m_hready[m];
			nxt_err_end[m] = err_ff[m];
		end
	end

	// Peripheral bus enables: high-speed every cycle, low-speed at half rate
	always_comb begin
		nxt_div = !div_ff;
	end
	assign hsp_clk_en = 1'b1;
	assign lsp_clk_en = div_ff;

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dph_ff     <= '0;
			rr_ff      <= '0;
			err_ff     <= '0;
			err_end_ff <= '0;
			div_ff     <= 1'b0;
		end else begin
			dph_ff     <= nxt_dph;
			rr_ff      <= nxt_rr;
			err_ff     <= nxt_err;
			err_end_ff <= nxt_err_end;
			div_ff     <= nxt_div;
		end
	end

	// Slave side muxes: address and control from the freshly granted master, write data from the data phase owner
	always_comb begin
		for (int s = 0; s < 4; s++) begin
			s_haddr[s]   = '0;
			s_htrans[s]  = abm_pkg::HTRANS_IDLE;
			s_hwrite[s]  = 1'b0;
			s_hsize[s]   = 3'h0;
			s_hwdata[s]  = '0;
			s_hmaster[s] = gnt[s];
			for (int m = 0; m < 4; m++) begin
				if (gnt[s][m] && s_hready[s]) begin
					s_haddr[s]  = m_haddr[m];
					s_htrans[s] = m_htrans[m];
					s_hwrite[s] = m_hwrite[m];
					s_hsize[s]  = m_hsize[m];
					if (s == abm_pkg::S_SRAM) begin
						s_haddr[s] = m_haddr[m] & abm_pkg::SRAM_OFS_MASK;
					end
				end
				if (dph_ff[s][m]) s_hwdata[s] = m_hwdata[m];
			end
		end
	end

	// Master side return: data phase owner, stall if waiting for grant
	always_comb begin
		for (int m = 0; m < 4; m++) begin
			m_hrdata[m] = '0;
			m_hready[m] = 1'b1;
			m_hresp[m]  = abm_pkg::HRESP_OKAY;
			for (int s = 0; s < 4; s++) begin
				if (dph_ff[s][m]) begin
					m_hrdata[m] = s_hrdata[s];
					m_hready[m] = s_hready[s];
					m_hresp[m]  = s_hresp[s];
				end
			end
			// A loser sees hready low until its slave grants it
			if (req_vld[m] && !gnt[req_slv[m][1:0]][m]) begin
				m_hready[m] = 1'b0;
			end
			if (err_ff[m]) begin
				m_hready[m] = 1'b0;
				m_hresp[m]  = abm_pkg::HRESP_ERR;
			end else if (err_end_ff[m]) begin
				m_hready[m] = 1'b1;
				m_hresp[m]  = abm_pkg::HRESP_ERR;
			end
		end
	end
endmodule

// ### abm_matrix_checker.sv
// Port assertions for the bus matrix
`timescale 1ns/1ps
module abm_matrix_checker #(
	parameter int AW = 32, // Address width
	parameter int DW = 32  // Data width
) (
	input wire logic               clk,        // Clock
	input wire logic               rstn,       // Reset, active low
	input wire logic [3:0][AW-1:0] m_haddr,    // Master addresses
	input wire logic [3:0][1:0]    m_htrans,   // Master transfer types
	input wire logic [3:0][DW-1:0] m_hwdata,   // Master write data
	input wire logic [3:0][DW-1:0] m_hrdata,   // Read data to masters
	input wire logic [3:0]         m_hready,   // Ready to masters
	input wire logic [3:0][1:0]    m_hresp,    // Response to masters
	input wire logic [3:0][AW-1:0] s_haddr,    // Slave addresses
	input wire logic [3:0][1:0]    s_htrans,   // Slave transfer types
	input wire logic [3:0][DW-1:0] s_hwdata,   // Slave write data
	input wire logic [3:0][3:0]    s_hmaster,  // Granted master
	input wire logic [3:0][DW-1:0] s_hrdata,   // Slave read data
	input wire logic [3:0]         s_hready,   // Slave ready
	input wire logic               lsp_clk_en, // Low-speed enable
	input wire logic               hsp_clk_en  // High-speed enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Blank pairs of the connectivity table
	a_no_sys_flash: assert property (s_hmaster[0][1] == 1'b0)
		else $error("System bus granted flash");
	a_no_code_periph: assert property (s_hmaster[3:2] == 8'h00 ||
		(s_hmaster[2][0] == 1'b0 && s_hmaster[3][0] == 1'b0))
		else $error("Code bus granted a peripheral slave");
	a_err_two_cycle: assert property (m_htrans[0][1] &&
		m_haddr[0][31:30] == 2'h1 && m_hready[0] |=> !m_hready[0] &&
		m_hresp[0] == 2'h1 ##1 m_hready[0] && m_hresp[0] == 2'h1)
		else $error("Code bus peripheral access not refused");
	// Routing, arbitration and data paths
	a_grant_onehot: assert property ($onehot0(s_hmaster[1]))
		else $error("SRAM granted to several masters");
	a_sram_alias: assert property (s_htrans[1][1] |->
		s_haddr[1][31:16] == 16'h0000)
		else $error("SRAM offset not folded");
	a_gpio_route: assert property (s_htrans[3][1] |->
		s_haddr[3][31:13] == 19'h24000)
		else $error("Non GPIO address on GPIO slave");
	a_rdata_mirror: assert property (s_htrans[1][1] && s_hmaster[1][1] &&
		s_hready[1] |=> m_hready[1] == s_hready[1] &&
		m_hrdata[1] == s_hrdata[1])
		else $error("SRAM answer not passed to system bus");
	a_wdata_path: assert property (s_htrans[1][1] && s_hmaster[1][2] &&
		s_hready[1] |=> s_hwdata[1] == m_hwdata[2])
		else $error("DMA write data not passed to SRAM");
	// Peripheral bus enables
	a_lsp_half: assert property (1'b1 |=> lsp_clk_en != $past(lsp_clk_en))
		else $error("Low-speed enable not alternating");
	a_hsp_full: assert property (hsp_clk_en == 1'b1)
		else $error("High-speed enable dropped");
endmodule
bind abm_matrix abm_matrix_checker #(.AW(AW), .DW(DW)) u_abm_matrix_checker (
	.clk(clk), .rstn(rstn), .m_haddr(m_haddr), .m_htrans(m_htrans),
	.m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
	.m_hresp(m_hresp), .s_haddr(s_haddr), .s_htrans(s_htrans),
	.s_hwdata(s_hwdata), .s_hmaster(s_hmaster), .s_hrdata(s_hrdata),
	.s_hready(s_hready), .lsp_clk_en(lsp_clk_en), .hsp_clk_en(hsp_clk_en)
);

// ### abm_pkg.sv
// Package of constants for the AHB multilayer bus matrix
package abm_pkg;
	localparam int NUM_MST  = 4;
	localparam int NUM_SLV  = 4;
	localparam int AW       = 32;
	localparam int DW       = 32;
	// Master indices
	localparam int M_CODE   = 0;
	localparam int M_SYS    = 1;
	localparam int M_DMA_PORT_FIRST   = 2;
	localparam int M_DMA_PORT_SECOND   = 3;
	// Slave indices
	localparam int S_FLASH  = 0;
	localparam int S_SRAM   = 1;
	localparam int S_PERIPH = 2;
	localparam int S_GPIO   = 3;
	// Connectivity, one bit per master, indexed by slave
	localparam logic [3:0] CONN_FLASH  = 4'hD;
	localparam logic [3:0] CONN_SRAM   = 4'hF;
	localparam logic [3:0] CONN_PERIPH = 4'hE;
	localparam logic [3:0] CONN_GPIO   = 4'hE;
	// Address windows
	localparam logic [31:0] FLASH_ALIAS_BASE = 32'h00000000;
	localparam logic [31:0] FLASH_ALIAS_END  = 32'h0005FFFF;
	localparam logic [31:0] FLASH_MAIN_BASE  = 32'h08000000;
	localparam logic [31:0] FLASH_MAIN_END   = 32'h0805FFFF;
	localparam logic [31:0] FLASH_DATA_BASE  = 32'h08800000;
	localparam logic [31:0] FLASH_DATA_END   = 32'h0880FFFF;
	localparam logic [31:0] FLASH_SYS_BASE   = 32'h1FFF7000;
	localparam logic [31:0] FLASH_SYS_END    = 32'h1FFFF817;
	localparam logic [31:0] SRAM_CODE_BASE   = 32'h0A000000;
	localparam logic [31:0] SRAM_CODE_END    = 32'h0A00CFFF;
	localparam logic [31:0] SRAM_SYS_BASE    = 32'h20000000;
	localparam logic [31:0] SRAM_SYS_END     = 32'h2000CFFF;
	localparam logic [31:0] SRAM_SHARED_OFS  = 32'h0000C000;
	localparam logic [31:0] SRAM_OFS_MASK    = 32'h0000FFFF;
	localparam logic [31:0] GPIO_BASE        = 32'h48000000;
	localparam logic [31:0] GPIO_END         = 32'h480017FF;
	localparam logic [31:0] PERIPH_BASE      = 32'h40000000;
	localparam logic [31:0] PERIPH_END       = 32'h5FFFFFFF;
	localparam int          PERIPH_WIN_LSB   = 10;
	// Peripheral clock limits and system clock in MHz
	localparam int LOW_SPEED_MAX_MHZ  = 50;
	localparam int HIGH_SPEED_MAX_MHZ = 100;
	localparam int SYS_CLK_MHZ        = 40;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY  = 2'h0;
	localparam logic [1:0] HRESP_ERR   = 2'h1;
endpackage

// ### abm_slv_model.sv
// Responder model for the four slave ports
`timescale 1ns/1ps
module abm_slv_model (
	input  wire logic             clk,    // Clock
	input  wire logic             rstn,   // Reset, active low
	input  wire logic [3:0][31:0] haddr,  // Slave addresses
	input  wire logic [3:0][1:0]  htrans, // Transfer types
	input  wire logic [3:0]       stall,  // Wait state request
	output logic      [3:0][31:0] hrdata, // Read data
	output logic      [3:0]       hready, // Ready
	output logic      [3:0][1:0]  hresp   // Response
);
	logic [3:0][31:0] addr_ff;
	logic [3:0]       dph_ff;
	// Capture each address phase the slave accepts
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dph_ff <= '0;
			addr_ff <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (hready[i]) begin
					dph_ff[i] <= htrans[i][1];
					addr_ff[i] <= haddr[i];
				end
			end
		end
	end
	// Data carries slave index; outside data phase it is inverted
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			hready[i] = !(stall[i] && dph_ff[i]);
			hresp[i] = 2'h0;
			hrdata[i] = {i[3:0], addr_ff[i][27:0]};
			if (!dph_ff[i]) hrdata[i] = ~hrdata[i];
		end
	end
endmodule

// ### tb_top.sv
// Self-checking testbench for the bus matrix
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
error_cnt++; $display("Error at %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	logic [3:0][31:0] m_haddr, m_hwdata, m_hrdata, s_haddr, s_hwdata, s_hrdata;
	logic [3:0][1:0]  m_htrans, m_hresp, s_htrans, s_hresp;
	logic [3:0][2:0]  m_hsize, s_hsize;
	logic [3:0]       m_hwrite, m_hready, s_hwrite, s_hready, stall;
	logic [3:0][3:0]  s_hmaster;
	logic             clk, rstn, lsp, hsp;
	int               error_cnt, samples_checked, cyc;
	abm_matrix u_abm_matrix (.clk(clk), .rstn(rstn), .m_haddr(m_haddr),
		.m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hsize(m_hsize),
		.m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
		.m_hresp(m_hresp), .s_haddr(s_haddr), .s_htrans(s_htrans),
		.s_hwrite(s_hwrite), .s_hsize(s_hsize), .s_hwdata(s_hwdata),
		.s_hmaster(s_hmaster), .s_hrdata(s_hrdata), .s_hready(s_hready),
		.s_hresp(s_hresp), .lsp_clk_en(lsp), .hsp_clk_en(hsp));
	abm_slv_model u_abm_slv_model (.clk(clk), .rstn(rstn), .haddr(s_haddr),
		.htrans(s_htrans), .stall(stall), .hrdata(s_hrdata),
		.hready(s_hready), .hresp(s_hresp));
	// Clock and hang guard
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wait_rdy(input int m);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (m_hready[m] !== 1'b1 && n < 10);
		`CHK(m_hready[m], 1'b1)
	endtask
	// One transfer by master m, a write when m is odd; expects a grant on slave s when ok
	task automatic xfer(input int m, input logic [31:0] a, input int s,
		input logic ok);
		logic [31:0] exp_d;
		logic [31:0] exp_a;
		exp_d = (s == 1) ? {16'h1000, a[15:0]} : {s[3:0], a[27:0]};
		exp_a = (s == 1) ? (a & abm_pkg::SRAM_OFS_MASK) : a;
		m_htrans[m] = abm_pkg::HTRANS_NSEQ;
		m_haddr[m] = a;
		m_hwrite[m] = m[0];
		#1 `CHK(s_hmaster[s][m], ok)
		if (ok) `CHK(s_haddr[s], exp_a)
		if (ok) `CHK(s_hwrite[s], m[0])
		if (ok) `CHK(s_hsize[s], 3'h2)
		wait_rdy(m);
		#1 m_htrans[m] = abm_pkg::HTRANS_IDLE;
		m_hwdata[m] = ~a;
		wait_rdy(m);
		`CHK(m_hresp[m], ok ? 2'h0 : 2'h1)
		if (ok) `CHK(m_hrdata[m], exp_d)
		if (ok) `CHK(s_hwdata[s], ~a)
		#1;
	endtask
	// Every master against every slave, plus the shared SRAM aliases
	task automatic t_conn;
		logic [3:0]  conn [4] = '{4'hD, 4'hF, 4'hE, 4'hE};
		logic [31:0] adr [4] = '{32'h08000100, 32'h20000040,
			32'h40013800, 32'h48000400};
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 4; s++) begin
				xfer(m, (m == 0 && s == 1) ? 32'h0A000040 : adr[s], s,
					conn[s][m]);
			end
		end
		xfer(0, 32'h0A00C010, 1, 1'b1);
		xfer(1, 32'h2000C010, 1, 1'b1);
		$display("Connectivity test done");
	endtask
	// Code to flash and system to GPIO at once, GPIO answering slowly
	task automatic t_par;
		m_htrans[1:0] = 4'hA;
		m_haddr[0] = 32'h08000200;
		m_haddr[1] = 32'h48000800;
		#1 `CHK(s_hmaster[0][0] & s_hmaster[3][1], 1'b1)
		@(posedge clk);
		`CHK(m_hready[1:0], 2'h3)
		#1 m_htrans[1:0] = 4'h0;
		stall[3] = 1'b1;
		@(posedge clk);
		`CHK(m_hready[1:0], 2'h1)
		#1 stall[3] = 1'b0;
		@(posedge clk);
		`CHK(m_hready[1], 1'b1)
		#1 $display("Parallel test done");
	endtask
	// All four masters contend for SRAM
	task automatic t_arb;
		logic [3:0] pend, got;
		int         n;
		pend = 4'hF;
		n = 0;
		m_htrans = 8'hAA;
		m_haddr = {{3{32'h20000100}}, 32'h0A000100};
		while (pend != 4'h0 && n < 12) begin
			@(posedge clk);
			n++;
			got = m_hready & pend;
			`CHK($countones(got), 1)
			#1 for (int i = 0; i < 4; i++) if (got[i]) m_htrans[i] = 2'h0;
			pend = pend & ~got;
		end
		`CHK(n, 4)
		@(posedge clk);
		#1 $display("Arbitration test done");
	endtask
	// Peripheral bus enables
	task automatic t_clk;
		logic prev;
		repeat (4) begin
			prev = lsp;
			@(posedge clk);
			#1 `CHK(lsp, ~prev)
			`CHK(hsp, 1'b1)
		end
		$display("Clock enable test done");
	endtask
	// Main sequence
	initial begin
		{m_haddr, m_hwdata, m_htrans, m_hwrite, stall} = '0;
		m_hsize = 12'h492;
		rstn = 0;
		error_cnt = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (6) @(posedge clk);
		#1 rstn = 1;
		t_conn();
		t_par();
		t_arb();
		t_clk();
		print_verdict();
	end
endmodule
